/* rtl/glcp_pkg.sv */
// glcp_pkg: constants for the line control / paging register block.
// assumes an 8-bit host register port and eight GPIB management lines.
package glcp_pkg;

  // ==========================================================
  // register offsets
  localparam logic [2:0] OFS_AUX = 3'h3;
  localparam logic [2:0] OFS_SHARED = 3'h2;

  // ==========================================================
  // auxiliary command codes
  localparam logic [7:0] CMD_PAGE_CLEAR = 8'h9c;
  localparam logic [7:0] CMD_EOS_PAGE = 8'h9e;
  localparam logic [7:0] CMD_ACC_PAGE = 8'h9f;
  localparam logic [7:0] CMD_LINE_PAGE = 8'h1f;
  localparam logic [7:0] CMD_CHIP_RESET = 8'h00;

  // ==========================================================
  // line bit positions
  localparam int BIT_ATN = 7;
  localparam int BIT_DAV = 6;
  localparam int BIT_NDAC = 5;
  localparam int BIT_NRFD = 4;
  localparam int BIT_EOI = 3;
  localparam int BIT_SRQ = 2;
  localparam int BIT_IFC = 1;
  localparam int BIT_REN = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_EOS = 8'h00;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [7:0] RST_LINE_CTRL = 8'h00;

  typedef enum logic [1:0] {
    GLCP_PAGE_NONE,
    GLCP_PAGE_EOS,
    GLCP_PAGE_ACC,
    GLCP_PAGE_LINE
  } glcp_page_e;

endpackage : glcp_pkg

/* rtl/glcp_line_io.sv */
// glcp_line_io: pin gating and internal line merge for eight lines.
// assumes direction enables come from the interface functions.
`timescale 1ns/10ps
module glcp_line_io
  import glcp_pkg::*;
(
  // control side
  input wire logic [7:0] ctrl_bits,
  input wire logic [7:0] func_out,
  input wire logic [7:0] tx_en,
  // pin side
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] line_in
);

  wire [7:0] want = func_out | ctrl_bits;
  // srq, ndac and nrfd are wired-or lines watched even while driven
  wire [7:0] wired_or_mask = (8'h01 << BIT_SRQ) | (8'h01 << BIT_NDAC)
                           | (8'h01 << BIT_NRFD);

  assign pin_out = want & tx_en;
  // transmitted lines show own value; received lines show the bus or'd with the control bit
  assign line_in = (tx_en & want) | (~tx_en & (pin_in | ctrl_bits))
                 | (wired_or_mask & (pin_in | want));

endmodule : glcp_line_io

/* rtl/glcp_top.sv */
// glcp_top: auxiliary paging of the shared slot and line control/status.
// assumes a synchronous host port with read data one cycle after strobe.
//
// Function
// - page clear unmaps the shared slot
// - after clear, shared slot writes ignored
// - code 9e pages end of string register
// - code 9f pages accessory register
// - page held until reset, clear, repage
// - code 1f pages line control/status
// - fixed line bit order atn..ren
// - status read samples lines live
// - control bit one requests line assertion
// - transmitted line driven when bit set
// - received line never driven by bit
// - internal line ors control bit
// - pin is request gated by enable
// - srq ndac nrfd or pin value
// - status shows transceiver side value
// - srq status shows pin or control bit while in charge
`timescale 1ns/10ps
module glcp_top
  import glcp_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // host register port
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // interface function side
  input wire logic [7:0] FUNC_OUT,
  input wire logic [7:0] TX_EN,
  input wire logic CIC,
  output logic [7:0] LINE_IN,
  // gpib pins
  input wire logic [7:0] PIN_I,
  output logic [7:0] PIN_O,
  output logic [7:0] PIN_OE,
  // register views
  output logic [7:0] EOS,
  output logic [7:0] ACC,
  output logic [1:0] PAGE
);

  // ==========================================================
  // decode
  glcp_page_e page;
  glcp_page_e next_page;
  logic [7:0] eos_reg;
  logic [7:0] acc_reg;
  logic [7:0] line_ctrl;
  logic [7:0] line_in_w;
  logic [7:0] pin_out_w;

  wire aux_wr = WR && (ADDR == OFS_AUX);
  wire slot_wr = WR && (ADDR == OFS_SHARED);
  wire slot_rd = RD && (ADDR == OFS_SHARED);
  wire chip_rst = aux_wr && (WDATA == CMD_CHIP_RESET);

  always_comb begin
    next_page = page;
    if (aux_wr) begin
      case (WDATA)
        CMD_PAGE_CLEAR: next_page = GLCP_PAGE_NONE;
        CMD_EOS_PAGE: next_page = GLCP_PAGE_EOS;
        CMD_ACC_PAGE: next_page = GLCP_PAGE_ACC;
        CMD_LINE_PAGE: next_page = GLCP_PAGE_LINE;
        CMD_CHIP_RESET: next_page = GLCP_PAGE_NONE;
        default: next_page = page;
      endcase
    end
  end

  // with no page the slot write lands nowhere
  wire wr_eos = slot_wr && (page == GLCP_PAGE_EOS);
  wire wr_acc = slot_wr && (page == GLCP_PAGE_ACC);
  wire wr_line = slot_wr && (page == GLCP_PAGE_LINE);

  // ==========================================================
  // line path
  glcp_line_io u_io (
    .ctrl_bits(line_ctrl),
    .func_out(FUNC_OUT),
    .tx_en(TX_EN),
    .pin_in(PIN_I),
    .pin_out(pin_out_w),
    .line_in(line_in_w)
  );

  // srq is an input while in charge, so the bus value or'd with the control bit is shown
  wire [7:0] status_w = CIC ?
    {line_in_w[7:3], PIN_I[BIT_SRQ] | line_ctrl[BIT_SRQ], line_in_w[1:0]}
    : line_in_w;

  wire [7:0] slot_rdata = (page == GLCP_PAGE_EOS) ? eos_reg :
                          (page == GLCP_PAGE_ACC) ? acc_reg :
                          (page == GLCP_PAGE_LINE) ? status_w : 8'h00;

  // ==========================================================
  // registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      page <= GLCP_PAGE_NONE;
      eos_reg <= RST_EOS;
      acc_reg <= RST_ACC;
      line_ctrl <= RST_LINE_CTRL;
    end else begin
      page <= next_page;
      if (chip_rst) begin
        line_ctrl <= RST_LINE_CTRL;
      end else if (wr_line) begin
        line_ctrl <= WDATA;
      end
      if (wr_eos) begin
        eos_reg <= WDATA;
      end
      if (wr_acc) begin
        acc_reg <= WDATA;
      end
    end
  end

  // outputs from flops; pins lag one cycle behind the request
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      PIN_O <= 8'h00;
      PIN_OE <= 8'h00;
      LINE_IN <= 8'h00;
      EOS <= RST_EOS;
      ACC <= RST_ACC;
      PAGE <= 2'h0;
    end else begin
      RDATA <= slot_rd ? slot_rdata : 8'h00;
      PIN_O <= pin_out_w;
      PIN_OE <= pin_out_w;
      LINE_IN <= line_in_w;
      EOS <= eos_reg;
      ACC <= acc_reg;
      PAGE <= next_page;
    end
  end

  // ==========================================================
  // checks
  sequence s_clear_cmd;
    aux_wr && WDATA == CMD_PAGE_CLEAR;
  endsequence
  sequence s_eos_cmd;
    aux_wr && WDATA == CMD_EOS_PAGE;
  endsequence
  sequence s_acc_cmd;
    aux_wr && WDATA == CMD_ACC_PAGE;
  endsequence
  sequence s_line_cmd;
    aux_wr && WDATA == CMD_LINE_PAGE;
  endsequence
  sequence s_chip_rst;
    chip_rst;
  endsequence
  sequence s_slot_write;
    slot_wr;
  endsequence

  a_page_clear_none:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_clear_cmd |=> page == GLCP_PAGE_NONE)
      else $error("page clear left a page mapped");

  a_clear_page_out:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_clear_cmd |=> PAGE == 2'h0)
      else $error("page view not cleared");

  a_none_read_zero:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_NONE |=> RDATA == 8'h00)
      else $error("unmapped slot read not zero");

  a_clear_blocks_wr:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (page == GLCP_PAGE_NONE && slot_wr) |=> $stable(eos_reg)
        && $stable(acc_reg) && $stable(line_ctrl))
      else $error("write landed with no page");

  a_clear_then_wr:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_clear_cmd ##1 s_slot_write |=> $stable(eos_reg)
        && $stable(acc_reg) && $stable(line_ctrl))
      else $error("write after clear landed");

  a_eos_page_map:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_eos_cmd |=> page == GLCP_PAGE_EOS)
      else $error("eos page not mapped");

  a_eos_write:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      wr_eos |=> eos_reg == $past(WDATA))
      else $error("eos write lost");

  a_eos_read:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_EOS |=> RDATA == $past(eos_reg))
      else $error("eos read wrong");

  a_eos_guard:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_wr && page != GLCP_PAGE_EOS |=> $stable(eos_reg))
      else $error("eos written while not paged");

  a_eos_after_page:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_eos_cmd ##1 s_slot_write |=> eos_reg == $past(WDATA))
      else $error("eos not reached after page in");

  a_acc_page_map:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_acc_cmd |=> page == GLCP_PAGE_ACC)
      else $error("accessory page not mapped");

  a_acc_write:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      wr_acc |=> acc_reg == $past(WDATA))
      else $error("accessory write lost");

  a_acc_read:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_ACC |=> RDATA == $past(acc_reg))
      else $error("accessory read wrong");

  a_acc_guard:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_wr && page != GLCP_PAGE_ACC |=> $stable(acc_reg))
      else $error("accessory written while not paged");

  a_acc_after_page:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_acc_cmd ##1 s_slot_write |=> acc_reg == $past(WDATA))
      else $error("accessory not reached after page in");

  a_page_hold:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !aux_wr |=> $stable(page))
      else $error("page changed without command");

  a_chip_rst_clear:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_chip_rst |=> page == GLCP_PAGE_NONE && line_ctrl == RST_LINE_CTRL)
      else $error("chip reset left page or control");

  a_line_page_map:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_line_cmd |=> page == GLCP_PAGE_LINE)
      else $error("line page not mapped");

  a_line_after_page:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_line_cmd ##1 s_slot_write |=> line_ctrl == $past(WDATA))
      else $error("line control not reached after page in");

  a_line_guard:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_wr && page != GLCP_PAGE_LINE |=> $stable(line_ctrl))
      else $error("line control written while not paged");

  a_line_write:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      wr_line |=> line_ctrl == $past(WDATA))
      else $error("line control not written");

  a_status_read:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_LINE |=> RDATA == $past(status_w))
      else $error("status read wrong");

  a_idle_read_zero:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !slot_rd |=> RDATA == 8'h00)
      else $error("read data without a slot read");

  // ==========================================================
  // checks: line path
  a_rx_not_driven:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (TX_EN == 8'h00) |=> PIN_OE == 8'h00)
      else $error("received line driven");

  a_rx_bits_off:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (PIN_OE & ~$past(TX_EN)) == 8'h00)
      else $error("received line bit driven");

  a_tx_driven:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (TX_EN & line_ctrl) != 8'h00 |=> (PIN_OE & $past(TX_EN & line_ctrl))
        == $past(TX_EN & line_ctrl))
      else $error("transmitted line not driven");

  a_pin_value:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      1'b1 |=> PIN_O == $past((FUNC_OUT | line_ctrl) & TX_EN))
      else $error("pin value not gated request");

  a_line_has_ctrl:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      1'b1 |=> (LINE_IN & $past(line_ctrl)) == $past(line_ctrl))
      else $error("internal line misses control bit");

  a_rx_atn_line:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !TX_EN[BIT_ATN] |=> LINE_IN[BIT_ATN] ==
        $past(PIN_I[BIT_ATN] | line_ctrl[BIT_ATN]))
      else $error("received atn not bus value");

  a_tx_eoi_own:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      TX_EN[BIT_EOI] |=> LINE_IN[BIT_EOI] ==
        $past(FUNC_OUT[BIT_EOI] | line_ctrl[BIT_EOI]))
      else $error("transmitted eoi not own value");

  a_wired_srq:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PIN_I[BIT_SRQ] |=> LINE_IN[BIT_SRQ])
      else $error("srq pin not merged");

  a_wired_ndac:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PIN_I[BIT_NDAC] |=> LINE_IN[BIT_NDAC])
      else $error("ndac pin not merged");

  a_wired_nrfd:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      PIN_I[BIT_NRFD] |=> LINE_IN[BIT_NRFD])
      else $error("nrfd pin not merged");

  a_srq_cic:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      CIC && PIN_I[BIT_SRQ] |-> status_w[BIT_SRQ])
      else $error("srq status hides bus while in charge");

  a_status_cic_srq:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_LINE && CIC |=> RDATA[BIT_SRQ] ==
        $past(PIN_I[BIT_SRQ] | line_ctrl[BIT_SRQ]))
      else $error("srq status read wrong while in charge");

  a_status_order:
    assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      slot_rd && page == GLCP_PAGE_LINE && !CIC |=>
        RDATA == $past(line_in_w))
      else $error("status bits out of order");

endmodule : glcp_top

/* dv/glcp_bus_model.sv */
// glcp_bus_model: wired-or gpib management lines, 1 = asserted.
// assumes released lines float to the deasserted level.
`timescale 1ns/10ps
module glcp_bus_model (
  // device side
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  // other instruments
  input wire logic [7:0] ext,
  output logic [7:0] pin_i
);
  // ==========================================================
  // bus
  // a released pin shows the pull-up, never the last driven value
  assign pin_i = (pin_o & pin_oe) | ext;
endmodule : glcp_bus_model

/* dv/test_glcp_line_control_paging.sv */
// test_glcp_line_control_paging: directed tests of paging and lines.
// assumes glcp_top and the wired-or bus model.
`timescale 1ns/10ps
module test_gpib_line_control_paging;
  import glcp_pkg::*;
  logic clk, rst_n, wr, rd, cic;
  logic [2:0] addr;
  logic [7:0] wd, fo, tx, ext, rdata, line, pi, po, poe, eos, acc;
  logic [1:0] page;
  int fail_count, n_checks;
  glcp_top u_glcp_top (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr),
    .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .FUNC_OUT(fo),
    .TX_EN(tx), .CIC(cic), .LINE_IN(line), .PIN_I(pi), .PIN_O(po),
    .PIN_OE(poe), .EOS(eos), .ACC(acc), .PAGE(page));
  glcp_bus_model u_glcp_bus_model (.pin_o(po), .pin_oe(poe),
    .ext(ext), .pin_i(pi));
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    settle();
  endtask : wrr
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask : rdc
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // ==========================================================
  // scenarios
  task automatic t_page;
    wrr(OFS_AUX, CMD_EOS_PAGE);
    chk("page", 8'h01, {6'h00, page});
    wrr(OFS_SHARED, 8'ha5);
    chk("eos", 8'ha5, eos);
    rdc(OFS_SHARED, 8'ha5);
    wrr(OFS_AUX, CMD_ACC_PAGE);
    chk("page", 8'h02, {6'h00, page});
    wrr(OFS_SHARED, 8'h3c);
    chk("acc", 8'h3c, acc);
    rdc(OFS_SHARED, 8'h3c);
    chk("eos", 8'ha5, eos);
    wrr(OFS_AUX, CMD_PAGE_CLEAR);
    chk("page", 8'h00, {6'h00, page});
    wrr(OFS_SHARED, 8'hff);
    chk("acc", 8'h3c, acc);
    chk("eos", 8'ha5, eos);
    rdc(OFS_SHARED, 8'h00);
    $display("end page test");
  endtask : t_page
  task automatic t_lines;
    wrr(OFS_AUX, CMD_LINE_PAGE);
    chk("page", 8'h03, {6'h00, page});
    wrr(OFS_SHARED, 8'ha5);
    chk("pin_o", 8'ha5, po);
    chk("pin_oe", 8'ha5, poe);
    @(posedge clk);
    tx <= 8'h00;
    settle();
    chk("pin_i", 8'h00, pi);
    chk("line", 8'ha5, line);
    @(posedge clk);
    ext <= 8'h42;
    settle();
    chk("line", 8'he7, line);
    rdc(OFS_SHARED, 8'he7);
    @(posedge clk);
    tx <= 8'hff;
    fo <= 8'h01;
    ext <= 8'h3c;
    cic <= 1'b1;
    wrr(OFS_SHARED, 8'h00);
    chk("line", 8'h35, line);
    rdc(OFS_SHARED, 8'h35);
    $display("end line test");
  endtask : t_lines
  task automatic t_resets;
    wrr(OFS_SHARED, 8'h80);
    wrr(OFS_AUX, CMD_CHIP_RESET);
    chk("page", 8'h00, {6'h00, page});
    chk("pin_o", 8'h01, po);
    wrr(OFS_AUX, CMD_EOS_PAGE);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk("page", 8'h00, {6'h00, page});
    wrr(OFS_SHARED, 8'h11);
    chk("eos", 8'h00, eos);
    $display("end reset test");
  endtask : t_resets
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #20us;
    fail_count++;
    results();
  end
  initial begin
    {rst_n, wr, rd, cic, addr, wd, fo, tx, ext} = '0;
    tx = 8'hff;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("page", 8'h00, {6'h00, page});
    chk("pin_oe", 8'h00, poe);
    t_page();
    t_lines();
    t_resets();
    results();
  end
endmodule : test_gpib_line_control_paging
